// ---- hw/rclk_top.sv ----
// reference clock output generator with register port
//
// The strobed register port and the address map are this design's own decisions.
`timescale 1ns/1ps
module rclk_top #(
  parameter int SRC_W = 2
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // candidate source clocks, sampled levels
  input wire logic [2**SRC_W-1:0] src_clk,
  // device sleep request
  input wire logic sleep,
  // reference clock output
  output logic refclk_out
);

  // ==========================================
  // helper functions

  // period in half source cycles
  function automatic logic [8:0] period_f(input logic [2:0] div);
    period_f = 9'h002 << div;
  endfunction

  // high time in half source cycles
  function automatic logic [8:0] hi_len_f(input logic [2:0] div,
                                          input logic [1:0] duty);
    logic [10:0] prod;
    prod = {9'h000, duty} * {2'b00, period_f(div)};
    hi_len_f = prod[10:2];
  endfunction

  // ==========================================
  // registers

  logic [7:0] ctrl_ff;
  logic [SRC_W-1:0] sel_ff;
  logic [7:0] rdata_ff;
  logic [7:0] cnt_ff;
  logic [7:0] nxt_cnt;
  logic prev_ff;
  logic out_ff;
  logic nxt_out;
  rclk_pkg::rclk_state_e state_ff;
  rclk_pkg::rclk_state_e nxt_state;

  logic en;
  logic [1:0] duty;
  logic [2:0] div;
  logic lvl;
  logic edge_seen;
  logic rise_seen;
  logic ctrl_wr;
  logic nxt_en;

  assign en = ctrl_ff[rclk_pkg::CTRL_EN_BIT];
  assign duty = ctrl_ff[rclk_pkg::CTRL_DUTY_LSB +: 2];
  assign div = ctrl_ff[rclk_pkg::CTRL_DIV_LSB +: 3];
  assign ctrl_wr = reg_wr && (reg_addr == rclk_pkg::ADDR_CTRL);
  assign nxt_en = ctrl_wr ? reg_wdata[rclk_pkg::CTRL_EN_BIT] : en;

  assign lvl = src_clk[sel_ff];
  assign edge_seen = (lvl != prev_ff);
  assign rise_seen = lvl && !prev_ff;

  // control register, duty defaults to fifty percent
  // duty reset value
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_ff <= rclk_pkg::CTRL_RESET;
    end else if (ctrl_wr) begin
      ctrl_ff <= reg_wdata;
    end
  end

  // source select register
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sel_ff <= rclk_pkg::SRC_RESET[SRC_W-1:0];
    end else if (reg_wr && (reg_addr == rclk_pkg::ADDR_SRC)) begin
      sel_ff <= reg_wdata[SRC_W-1:0];
    end
  end

  // read data stands one cycle after the strobe
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_ff <= 8'h00;
    end else if (reg_rd) begin
      if (reg_addr == rclk_pkg::ADDR_CTRL) begin
        rdata_ff <= ctrl_ff;
      end else if (reg_addr == rclk_pkg::ADDR_SRC) begin
        rdata_ff <= {{(8-SRC_W){1'b0}}, sel_ff};
      end else if (reg_addr == rclk_pkg::ADDR_STAT) begin
        rdata_ff <= {6'h00, out_ff, state_ff == rclk_pkg::RCLK_RUN};
      end else begin
        rdata_ff <= 8'h00;
      end
    end else begin
      rdata_ff <= 8'h00;
    end
  end

  assign reg_rdata = rdata_ff;

  // ==========================================
  // divider engine

  always_comb begin
    nxt_state = state_ff;
    nxt_cnt = cnt_ff;
    nxt_out = out_ff;
    if (!nxt_en) begin
      nxt_state = rclk_pkg::RCLK_IDLE;
      nxt_cnt = 8'h00;
      nxt_out = 1'b0;
    end else if (sleep) begin
      nxt_state = state_ff;
    end else begin
      case (state_ff)
        rclk_pkg::RCLK_IDLE: begin
          nxt_state = rclk_pkg::RCLK_ARM;
        end
        rclk_pkg::RCLK_ARM: begin
          // wait for a source rising edge
          // so the first pulse is a full one, never a cut one
          if (rise_seen) begin
            nxt_state = rclk_pkg::RCLK_RUN;
            nxt_cnt = 8'h00;
            nxt_out = (div == 3'h0) || (duty != 2'h0);
          end
        end
        rclk_pkg::RCLK_RUN: begin
          if (div == 3'h0) begin
            nxt_out = lvl;
          end else if (edge_seen) begin
            if ({1'b0, cnt_ff} >= period_f(div) - 9'h001) begin
              nxt_cnt = 8'h00;
            end else begin
              nxt_cnt = cnt_ff + 8'h01;
            end
            // code 00 gives no high time
            nxt_out = {1'b0, nxt_cnt} < hi_len_f(div, duty);
          end
        end
        default: begin
          nxt_state = rclk_pkg::RCLK_IDLE;
        end
      endcase
    end
  end

  // engine clocked by system clock only
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= rclk_pkg::RCLK_IDLE;
      cnt_ff <= 8'h00;
      out_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
      out_ff <= nxt_out;
    end
  end

  // source level history, frozen in sleep
  // a source change during sleep is then counted once on wake
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      prev_ff <= 1'b0;
    end else if (!sleep) begin
      prev_ff <= lvl;
    end
  end

  assign refclk_out = out_ff;

  // ==========================================
  // assertions

  logic ctrl_seen_ff;
  logic run;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_seen_ff <= 1'b0;
    end else if (ctrl_wr) begin
      ctrl_seen_ff <= 1'b1;
    end
  end

  assign run = (state_ff == rclk_pkg::RCLK_RUN);

  default clocking cb @(posedge ref_clk);
  endclocking

  default disable iff (!rst_n);

  a_src_select: assert property (
    reg_wr && reg_addr == rclk_pkg::ADDR_SRC
    |=> sel_ff == $past(reg_wdata[SRC_W-1:0]))
    else $error("source select not taken");

  a_clean_start: assert property (
    state_ff == rclk_pkg::RCLK_ARM && rise_seen && nxt_en && !sleep
    |=> run && cnt_ff == 8'h00)
    else $error("start not aligned to source edge");

  a_idle_low: assert property (
    state_ff != rclk_pkg::RCLK_RUN |-> !refclk_out)
    else $error("output high before start");

  a_stop_now: assert property (
    ctrl_wr && !reg_wdata[rclk_pkg::CTRL_EN_BIT]
    |=> !refclk_out && state_ff == rclk_pkg::RCLK_IDLE)
    else $error("output not stopped at once");

  a_cnt_step: assert property (
    run && nxt_en && !sleep && div != 3'h0 && edge_seen
    && {1'b0, cnt_ff} < period_f(div) - 9'h001
    |=> cnt_ff == $past(cnt_ff) + 8'h01)
    else $error("half period count did not step");

  a_cnt_wrap: assert property (
    run && nxt_en && !sleep && div != 3'h0 && edge_seen
    && {1'b0, cnt_ff} >= period_f(div) - 9'h001
    |=> cnt_ff == 8'h00)
    else $error("count did not wrap at period end");

  a_duty_level: assert property (
    run && nxt_en && !sleep && div != 3'h0 && edge_seen
    |=> refclk_out == ({3'b000, cnt_ff, 2'b00}
        < ({10'h000, $past(duty), 1'b0} << $past(div))))
    else $error("output level disagrees with duty");

  a_stat_flags: assert property (
    reg_rd && reg_addr == rclk_pkg::ADDR_STAT
    |=> reg_rdata[rclk_pkg::STAT_RUN_BIT] == $past(run)
    && reg_rdata[rclk_pkg::STAT_OUT_BIT] == $past(refclk_out))
    else $error("status flags wrong");

  a_duty_zero: assert property (
    run && nxt_en && !sleep && div != 3'h0 && duty == 2'h0
    && edge_seen |=> !refclk_out)
    else $error("duty code zero drove output high");

  a_base_pass: assert property (
    run && nxt_en && !sleep && div == 3'h0 |=> refclk_out == $past(lvl))
    else $error("base rate not passed through");

  a_duty_reset: assert property (
    !ctrl_seen_ff |-> duty == rclk_pkg::DUTY_RESET)
    else $error("duty reset value wrong");

  a_sleep_hold: assert property (
    sleep && nxt_en |=> $stable(refclk_out) && $stable(cnt_ff)
    && $stable(state_ff))
    else $error("engine moved during sleep");

  a_wake_state: assert property (
    (sleep && !reg_wr) [*2] |-> $stable(ctrl_ff) && $stable(sel_ff))
    else $error("configuration changed in sleep");

  c_start: cover property (
    state_ff == rclk_pkg::RCLK_ARM ##1 run);
  c_wrap: cover property (
    run && div != 3'h0 ##1 cnt_ff == 8'h00 ##1 cnt_ff == 8'h01);
  c_stop_high: cover property (
    refclk_out && ctrl_wr && !reg_wdata[rclk_pkg::CTRL_EN_BIT]);
  c_sleep_run: cover property (run && sleep ##1 run && !sleep);
  c_base_rate: cover property (
    run && div == 3'h0 && refclk_out);

endmodule

// ---- pkg/rclk_pkg.sv ----
// constants shared by the reference clock output block
package rclk_pkg;
  // ==========================================
  // register offsets
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_SRC = 8'h01;
  localparam logic [7:0] ADDR_STAT = 8'h02;
  // ==========================================
  // control and status register fields
  localparam int CTRL_EN_BIT = 7;
  localparam int CTRL_DUTY_LSB = 3;
  localparam int CTRL_DIV_LSB = 0;
  localparam int STAT_RUN_BIT = 0;
  localparam int STAT_OUT_BIT = 1;
  // ==========================================
  // reset values
  localparam logic [7:0] CTRL_RESET = 8'h10;
  localparam logic [1:0] DUTY_RESET = 2'h2;
  localparam logic [7:0] SRC_RESET = 8'h00;
  // ==========================================
  // engine states
  typedef enum logic [1:0] {
    RCLK_IDLE = 2'b00,
    RCLK_ARM = 2'b01,
    RCLK_RUN = 2'b10
  } rclk_state_e;
endpackage

// ---- verification/rclk_sink.sv ----
// sink model that measures high time and period of the reference clock
`timescale 1ns/1ps
module rclk_sink (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // observed clock
  input wire logic clk_in,
  // high time and period in system clock cycles, and falling edge count
  output logic [15:0] hi_len,
  output logic [15:0] per_len,
  output logic [15:0] n_fall
);
  logic prev_ff;
  logic [15:0] hi_ff;
  logic [15:0] per_ff;
  // ====
  // edge timing
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      prev_ff <= 1'b0;
      hi_ff <= 16'h0000;
      per_ff <= 16'h0000;
      hi_len <= 16'h0000;
      per_len <= 16'h0000;
      n_fall <= 16'h0000;
    end else begin
      prev_ff <= clk_in;
      per_ff <= (clk_in && !prev_ff) ? 16'h0001 : per_ff + 16'h0001;
      hi_ff <= prev_ff ? hi_ff + 16'h0001 : 16'h0001;
      if (clk_in && !prev_ff) begin
        per_len <= per_ff;
      end
      if (!clk_in && prev_ff) begin
        hi_len <= hi_ff;
        n_fall <= n_fall + 16'h0001;
      end
    end
  end
endmodule

// ---- verification/reference_clock_output_tb.sv ----
// self-checking bench for the reference clock output block
`timescale 1ns/1ps
module reference_clock_output_tb;
  logic ref_clk;
  logic rst_n;
  logic [7:0] reg_addr;
  logic [7:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic [7:0] reg_rdata;
  logic [3:0] src_clk = 4'h0;
  logic sleep;
  logic refclk_out;
  logic [15:0] hi_len;
  logic [15:0] per_len;
  logic [15:0] n_fall;
  logic [7:0] tick = 8'h00;
  logic lvl;
  int n0;
  int n_mismatch;
  int checks;
  rclk_top #(.SRC_W(2)) dut (.ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .src_clk(src_clk), .sleep(sleep), .refclk_out(refclk_out));
  rclk_sink sink (.ref_clk(ref_clk), .rst_n(rst_n), .clk_in(refclk_out),
    .hi_len(hi_len), .per_len(per_len), .n_fall(n_fall));
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end
  // source k has a half period of 2^(k+1) system cycles
  always @(posedge ref_clk) begin
    tick <= tick + 8'h01;
    src_clk <= tick[4:1];
  end
  // ====
  // access and check tasks
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1;
    chk({8'h00, reg_rdata}, {8'h00, exp});
  endtask
  task automatic wait_fall(input int n);
    int k;
    k = 0;
    while (n_fall !== n[15:0] && k < 3000) begin
      @(posedge ref_clk);
      #1;
      k++;
    end
    if (k == 3000) chk(n_fall, n[15:0]);
  endtask
  // enable, measure first pulse and steady period, then disable
  task automatic run(input logic [7:0] src, input logic [7:0] ctrl, input int per, input int hi);
    int m;
    m = n_fall;
    wr(rclk_pkg::ADDR_SRC, src);
    wr(rclk_pkg::ADDR_CTRL, ctrl | 8'h80);
    wait_fall(m + 1);
    chk(hi_len, hi[15:0]);
    wait_fall(m + 3);
    chk(per_len, per[15:0]);
    chk(hi_len, hi[15:0]);
    // disable in the high phase so the stop cuts every pulse longer than two cycles
    while (refclk_out !== 1'b1) begin
      @(posedge ref_clk);
      #1;
    end
    wr(rclk_pkg::ADDR_CTRL, ctrl);
    #1;
    chk(16'(refclk_out), 16'h0000);
    rd(rclk_pkg::ADDR_STAT, 8'h00);
  endtask
  task automatic report_and_stop;
    $display("checks=%0d mismatches=%0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // ====
  // watchdog
  initial begin
    repeat (60000) @(posedge ref_clk);
    n_mismatch++;
    report_and_stop();
  end
  // ====
  // scenarios
  initial begin
    rst_n = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    sleep = 1'b0;
    n_mismatch = 0;
    checks = 0;
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'b1;
    rd(rclk_pkg::ADDR_CTRL, rclk_pkg::CTRL_RESET);
    rd(rclk_pkg::ADDR_SRC, rclk_pkg::SRC_RESET);
    rd(8'h05, 8'h00);
    for (int d = 0; d < 8; d++) run(8'h00, 8'h10 | d[7:0], 4 << d, 2 << d);
    run(8'h00, 8'h08, 4, 2);
    for (int c = 1; c < 4; c++) run(8'h00, 8'h02 | (c[7:0] << 3), 16, 4 * c);
    run(8'h01, 8'h11, 16, 8);
    run(8'h03, 8'h10, 32, 16);
    n0 = n_fall;
    wr(rclk_pkg::ADDR_CTRL, 8'h81);
    repeat (64) @(posedge ref_clk);
    #1;
    chk(n_fall, n0[15:0]);
    chk(16'(refclk_out), 16'h0000);
    wr(rclk_pkg::ADDR_CTRL, 8'h01);
    wr(rclk_pkg::ADDR_SRC, 8'h00);
    wr(rclk_pkg::ADDR_CTRL, 8'h93);
    wait_fall(n_fall + 1);
    repeat (20) @(posedge ref_clk);
    sleep <= 1'b1;
    @(posedge ref_clk);
    #1;
    lvl = refclk_out;
    n0 = n_fall;
    repeat (40) @(posedge ref_clk);
    #1;
    chk(16'(refclk_out), 16'(lvl));
    chk(n_fall, n0[15:0]);
    rd(rclk_pkg::ADDR_CTRL, 8'h93);
    rd(rclk_pkg::ADDR_STAT, 8'h03);
    @(posedge ref_clk);
    sleep <= 1'b0;
    wait_fall(n0 + 3);
    chk(per_len, 16'h0020);
    n0 = n_fall;
    wr(rclk_pkg::ADDR_CTRL, 8'h91);
    wait_fall(n0 + 3);
    chk(per_len, 16'h0008);
    wr(rclk_pkg::ADDR_CTRL, 8'h11);
    report_and_stop();
  end
endmodule
